// ### hdl/clkpm_params.svh
`ifndef CLKPM_PARAMS_SVH
`define CLKPM_PARAMS_SVH

// Register word indices; byte address is four times the index.
`define IDX_TIMER_A_INPUT_SOURCE_SELECT 6'h1A
`define IDX_PERIPH_CLOCK_ENABLE         6'h20
`define IDX_STOP_DISABLE                6'h21
`define IDX_CLOCK_RATE_CONTROL          6'h22
`define IDX_POWER_STATUS                6'h23

// Field positions.
`define POS_TIMER_CH1_SOURCE_SEL 4
`define POS_TIMER_CH2_SOURCE_SEL 8
`define POS_TIMER_CH3_SOURCE_SEL 12
`define TSEL_WRITE_MASK          16'h1110

// Reset values.
`define RST_TIMER_A_INPUT_SOURCE_SELECT 16'h0000
`define RST_PERIPH_CLOCK_ENABLE         8'hFF
`define RST_STOP_DISABLE                8'h00

// Watchdog divider: one watchdog period spans 1024 oscillator cycles.
`define WDOG_DIV      1024
`define WDOG_HALF_CNT 9'h1FF

// Master oscillator source codes.
`define OSC_SRC_RELAX 2'h2

// Number of gated peripheral clocks and of fast-capable peripherals.
`define NUM_PERIPH 8
`define NUM_FAST   4

`endif

// ### hdl/clkpm_pkg.sv
package clkpm_pkg;

	// Power modes, Gray coded along run, wait, stop, power-down.
	typedef enum logic [1:0] {
		MODE_RUN   = 2'b00,
		MODE_WAIT  = 2'b01,
		MODE_STOP  = 2'b11,
		MODE_PDOWN = 2'b10
	} mode_t;

	// Relaxation oscillator speed as reported in status.
	typedef enum logic [1:0] {
		OSC_FULL    = 2'b00,
		OSC_STANDBY = 2'b01,
		OSC_OFF     = 2'b10
	} osc_speed_t;

	typedef enum logic [1:0] {
		RESP_OKAY   = 2'b00,
		RESP_SLVERR = 2'b10
	} resp_t;

endpackage

// ### hdl/clock_gate_cell.sv
// Latch-based clock gate; the enable passes only while the clock is low.
module clock_gate_cell (
	input  wire logic clk_in,
	input  wire logic enable,
	output wire logic clk_out
);

	logic en_latch;

	// Transparent while the clock is low, so the output never glitches.
	always_latch begin
		if (!clk_in) begin
			en_latch <= enable;
		end
	end

	assign clk_out = clk_in & en_latch;

endmodule

// ### hdl/system_clock_power_mode_control.sv
// Design decision made here: the AXI4-Lite register port.
`include "clkpm_params.svh"

module system_clock_power_mode_control (
	input  wire logic                   REF_CLK,
	input  wire logic                   SYS_RST,
	input  wire logic                   FAST_CLK_3X,
	input  wire logic                   OSCILLATOR_CLOCK,
	// AXI4-Lite slave.
	input  wire logic [7:0]             S_AXI_AWADDR,
	input  wire logic                   S_AXI_AWVALID,
	output wire logic                   S_AXI_AWREADY,
	input  wire logic [31:0]            S_AXI_WDATA,
	input  wire logic [3:0]             S_AXI_WSTRB,
	input  wire logic                   S_AXI_WVALID,
	output wire logic                   S_AXI_WREADY,
	output wire logic [1:0]             S_AXI_BRESP,
	output wire logic                   S_AXI_BVALID,
	input  wire logic                   S_AXI_BREADY,
	input  wire logic [7:0]             S_AXI_ARADDR,
	input  wire logic                   S_AXI_ARVALID,
	output wire logic                   S_AXI_ARREADY,
	output wire logic [31:0]            S_AXI_RDATA,
	output wire logic [1:0]             S_AXI_RRESP,
	output wire logic                   S_AXI_RVALID,
	input  wire logic                   S_AXI_RREADY,
	// Core and clock generation module status.
	input  wire logic                   WAIT_REQ,
	input  wire logic                   STOP_REQ,
	input  wire logic                   DEBUG_ENTRY,
	input  wire logic                   LVI_IRQ,
	input  wire logic [`NUM_PERIPH-1:0] PERIPH_IRQ,
	input  wire logic [1:0]             MASTER_OSCILLATOR_SOURCE,
	input  wire logic                   PLL_SELECT,
	input  wire logic                   PLL_POWERDOWN,
	input  wire logic                   RELAX_OSC_STANDBY,
	input  wire logic                   RELAX_OSC_POWERDOWN,
	input  wire logic                   LARGE_REGULATOR_STANDBY,
	// Timer A input sources and selected timer inputs.
	input  wire logic                   TIMER_CH1_PIN,
	input  wire logic                   TIMER_CH2_PIN,
	input  wire logic                   TIMER_CH3_PIN,
	input  wire logic                   COMPARATOR_FIRST_OUT,
	input  wire logic                   COMPARATOR_SECOND_OUT,
	input  wire logic                   PWM_RELOAD_SYNC,
	output wire logic                   TIMER_CH1_IN,
	output wire logic                   TIMER_CH2_IN,
	output wire logic                   TIMER_CH3_IN,
	// Clock and power mode outputs.
	output wire logic                   CORE_CLK,
	output wire logic [`NUM_PERIPH-1:0] PERIPH_CLK,
	output wire logic [`NUM_FAST-1:0]   FAST_PERIPH_CLK,
	output wire logic                   WATCHDOG_CLK,
	output wire logic [1:0]             POWER_MODE
);

	// ==========================================================
	// Registers and state
	// ==========================================================
	logic [15:0]             tsel_reg;
	logic [`NUM_PERIPH-1:0]  clken_reg;
	logic [`NUM_PERIPH-1:0]  stopdis_reg;
	logic                    hs_en_reg;
	clkpm_pkg::mode_t        mode_reg;
	clkpm_pkg::mode_t        mode_next;
	logic                    sys_div_reg;
	logic [4:0]              sync1_reg;
	logic [4:0]              sync2_reg;
	logic [3:1]              tmr_in_reg;
	logic                    osc1_reg;
	logic                    osc2_reg;
	logic                    osc3_reg;
	logic [8:0]              wdog_cnt_reg;
	logic                    wdog_clk_reg;
	logic                    aw_hold_reg;
	logic                    w_hold_reg;
	logic [5:0]              awidx_reg;
	logic [31:0]             wdata_reg;
	logic [3:0]              wstrb_reg;
	logic                    bvalid_reg;
	logic [1:0]              bresp_reg;
	logic                    rvalid_reg;
	logic [31:0]             rdata_reg;
	logic [1:0]              rresp_reg;

	logic                    pll_ok;
	logic                    standby_cfg;
	logic                    pdown_cond;
	logic                    any_irq;
	logic                    stop_wake;
	logic                    core_en;
	logic [`NUM_PERIPH-1:0]  periph_en;
	logic [`NUM_FAST-1:0]    fast_en;
	logic                    wr_fire;
	logic                    wr_hit;
	logic [31:0]             rd_word;
	logic                    rd_hit;
	clkpm_pkg::osc_speed_t   osc_speed;

	// ==========================================================
	// Clock configuration decode
	// ==========================================================
	// The high-speed option needs the PLL powered and selected.
	assign pll_ok = PLL_SELECT & ~PLL_POWERDOWN;
	// Standby configuration: relaxation source, no PLL, slow oscillator, regulator idle.
	assign standby_cfg = (MASTER_OSCILLATOR_SOURCE == `OSC_SRC_RELAX) & ~PLL_SELECT &
		PLL_POWERDOWN & RELAX_OSC_STANDBY & LARGE_REGULATOR_STANDBY;
	// In Run, powering the oscillator down from Standby enters Power-Down.
	assign pdown_cond = standby_cfg & RELAX_OSC_POWERDOWN;
	assign any_irq = (|PERIPH_IRQ) | LVI_IRQ;
	// Only peripherals kept clocked in Stop, the LVI interrupt, or DEBUG_ENTRY can wake the device from Stop.
	assign stop_wake = (|(PERIPH_IRQ & stopdis_reg & clken_reg)) | LVI_IRQ;

	// Oscillator speed reported from its two control bits.
	always_comb begin
		if (RELAX_OSC_POWERDOWN) begin
			osc_speed = clkpm_pkg::OSC_OFF;
		end else if (RELAX_OSC_STANDBY) begin
			osc_speed = clkpm_pkg::OSC_STANDBY;
		end else begin
			osc_speed = clkpm_pkg::OSC_FULL;
		end
	end

	// ==========================================================
	// Power mode sequencing
	// ==========================================================
	// Next mode from core requests and wake-up events.
	always_comb begin
		case (mode_reg)
			clkpm_pkg::MODE_RUN: begin
				if (pdown_cond) begin
					mode_next = clkpm_pkg::MODE_PDOWN;
				end else if (STOP_REQ) begin
					mode_next = clkpm_pkg::MODE_STOP;
				end else if (WAIT_REQ) begin
					mode_next = clkpm_pkg::MODE_WAIT;
				end else begin
					mode_next = clkpm_pkg::MODE_RUN;
				end
			end
			clkpm_pkg::MODE_WAIT: begin
				mode_next = (any_irq | DEBUG_ENTRY) ? clkpm_pkg::MODE_RUN :
					clkpm_pkg::MODE_WAIT;
			end
			clkpm_pkg::MODE_STOP: begin
				mode_next = (stop_wake | DEBUG_ENTRY) ? clkpm_pkg::MODE_RUN :
					clkpm_pkg::MODE_STOP;
			end
			clkpm_pkg::MODE_PDOWN: begin
				mode_next = clkpm_pkg::MODE_PDOWN;
			end
			default: begin
				mode_next = clkpm_pkg::MODE_RUN;
			end
		endcase
	end

	// Mode register; any reset returns to Run.
	always_ff @(posedge REF_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			mode_reg <= clkpm_pkg::MODE_RUN;
		end else begin
			mode_reg <= mode_next;
		end
	end

	assign POWER_MODE = mode_reg;

	// ==========================================================
	// Clock enables and gates
	// ==========================================================
	// Core and memory clocks run only in Run.
	assign core_en = (mode_reg == clkpm_pkg::MODE_RUN);

	// Peripheral clocks run in Run and Wait, in Stop only when kept alive.
	always_comb begin
		for (int i = 0; i < `NUM_PERIPH; i++) begin
			periph_en[i] = clken_reg[i] & ((mode_reg == clkpm_pkg::MODE_RUN) |
				(mode_reg == clkpm_pkg::MODE_WAIT) |
				((mode_reg == clkpm_pkg::MODE_STOP) & stopdis_reg[i]));
		end
	end

	// The 3X clock follows its peripheral, the PLL and the high-speed option.
	assign fast_en = periph_en[`NUM_FAST-1:0] &
		{`NUM_FAST{hs_en_reg & pll_ok & ~standby_cfg}};

	// The system clock is the master clock halved.
	always_ff @(posedge REF_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			sys_div_reg <= 1'b0;
		end else begin
			sys_div_reg <= ~sys_div_reg;
		end
	end

	clock_gate_cell core_gate (
		.clk_in  (sys_div_reg),
		.enable  (core_en),
		.clk_out (CORE_CLK)
	);

	// One gate per peripheral on the system clock, one per fast peripheral on 3X.
	for (genvar g = 0; g < `NUM_PERIPH; g++) begin : g_periph
		clock_gate_cell periph_gate (
			.clk_in  (sys_div_reg),
			.enable  (periph_en[g]),
			.clk_out (PERIPH_CLK[g])
		);
	end

	for (genvar f = 0; f < `NUM_FAST; f++) begin : g_fast
		clock_gate_cell fast_gate (
			.clk_in  (FAST_CLK_3X),
			.enable  (fast_en[f]),
			.clk_out (FAST_PERIPH_CLK[f])
		);
	end

	// ==========================================================
	// Watchdog clock
	// ==========================================================
	// The oscillator clock is synchronised, then its rising edges are counted.
	always_ff @(posedge REF_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			osc1_reg     <= 1'b0;
			osc2_reg     <= 1'b0;
			osc3_reg     <= 1'b0;
			wdog_cnt_reg <= 9'h000;
			wdog_clk_reg <= 1'b0;
		end else begin
			osc1_reg <= OSCILLATOR_CLOCK;
			osc2_reg <= osc1_reg;
			osc3_reg <= osc2_reg;
			if (mode_reg == clkpm_pkg::MODE_PDOWN) begin
				wdog_clk_reg <= 1'b0;
			end else if (osc2_reg & ~osc3_reg) begin
				wdog_cnt_reg <= wdog_cnt_reg + 9'h001;
				if (wdog_cnt_reg == `WDOG_HALF_CNT) begin
					wdog_clk_reg <= ~wdog_clk_reg;
				end
			end
		end
	end

	assign WATCHDOG_CLK = wdog_clk_reg;

	// ==========================================================
	// Timer A input source routing
	// ==========================================================
	// Pins and comparator outputs pass two flip-flops first.
	always_ff @(posedge REF_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			sync1_reg <= 5'h00;
			sync2_reg <= 5'h00;
		end else begin
			sync1_reg <= {COMPARATOR_SECOND_OUT, COMPARATOR_FIRST_OUT,
				TIMER_CH3_PIN, TIMER_CH2_PIN, TIMER_CH1_PIN};
			sync2_reg <= sync1_reg;
		end
	end

	// Registered source multiplexers.
	always_ff @(posedge REF_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			tmr_in_reg <= 3'h0;
		end else begin
			tmr_in_reg[1] <= tsel_reg[`POS_TIMER_CH1_SOURCE_SEL] ? sync2_reg[3] :
				sync2_reg[0];
			tmr_in_reg[2] <= tsel_reg[`POS_TIMER_CH2_SOURCE_SEL] ? sync2_reg[4] :
				sync2_reg[1];
			tmr_in_reg[3] <= tsel_reg[`POS_TIMER_CH3_SOURCE_SEL] ? PWM_RELOAD_SYNC :
				sync2_reg[2];
		end
	end

	assign TIMER_CH1_IN = tmr_in_reg[1];
	assign TIMER_CH2_IN = tmr_in_reg[2];
	assign TIMER_CH3_IN = tmr_in_reg[3];

	// ==========================================================
	// AXI4-Lite write path
	// ==========================================================
	assign S_AXI_AWREADY = ~aw_hold_reg & ~bvalid_reg;
	assign S_AXI_WREADY  = ~w_hold_reg & ~bvalid_reg;
	assign wr_fire = aw_hold_reg & w_hold_reg & ~bvalid_reg;
	assign wr_hit = (awidx_reg == `IDX_TIMER_A_INPUT_SOURCE_SELECT) |
		(awidx_reg == `IDX_PERIPH_CLOCK_ENABLE) | (awidx_reg == `IDX_STOP_DISABLE) |
		(awidx_reg == `IDX_CLOCK_RATE_CONTROL);

	// Address and data are held until both are in, then answered.
	always_ff @(posedge REF_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			aw_hold_reg <= 1'b0;
			w_hold_reg  <= 1'b0;
			awidx_reg   <= 6'h00;
			wdata_reg   <= 32'h0000_0000;
			wstrb_reg   <= 4'h0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= clkpm_pkg::RESP_OKAY;
		end else begin
			if (S_AXI_AWVALID & S_AXI_AWREADY) begin
				aw_hold_reg <= 1'b1;
				awidx_reg   <= S_AXI_AWADDR[7:2];
			end
			if (S_AXI_WVALID & S_AXI_WREADY) begin
				w_hold_reg <= 1'b1;
				wdata_reg  <= S_AXI_WDATA;
				wstrb_reg  <= S_AXI_WSTRB;
			end
			if (wr_fire) begin
				aw_hold_reg <= 1'b0;
				w_hold_reg  <= 1'b0;
				bvalid_reg  <= 1'b1;
				bresp_reg   <= wr_hit ? clkpm_pkg::RESP_OKAY : clkpm_pkg::RESP_SLVERR;
			end else if (bvalid_reg & S_AXI_BREADY) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	assign S_AXI_BVALID = bvalid_reg;
	assign S_AXI_BRESP  = bresp_reg;

	// Software registers; reserved select bits never store.
	always_ff @(posedge REF_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			tsel_reg    <= `RST_TIMER_A_INPUT_SOURCE_SELECT;
			clken_reg   <= `RST_PERIPH_CLOCK_ENABLE;
			stopdis_reg <= `RST_STOP_DISABLE;
			hs_en_reg   <= 1'b0;
		end else begin
			if (wr_fire & (awidx_reg == `IDX_TIMER_A_INPUT_SOURCE_SELECT)) begin
				if (wstrb_reg[0]) begin
					tsel_reg[7:0] <= wdata_reg[7:0] & 8'(`TSEL_WRITE_MASK);
				end
				if (wstrb_reg[1]) begin
					tsel_reg[15:8] <= wdata_reg[15:8] & 8'(`TSEL_WRITE_MASK >> 8);
				end
			end
			if (wr_fire & (awidx_reg == `IDX_PERIPH_CLOCK_ENABLE) & wstrb_reg[0]) begin
				clken_reg <= wdata_reg[7:0];
			end
			if (wr_fire & (awidx_reg == `IDX_STOP_DISABLE) & wstrb_reg[0]) begin
				stopdis_reg <= wdata_reg[7:0];
			end
			if (!pll_ok) begin
				hs_en_reg <= 1'b0;
			end else if (wr_fire & (awidx_reg == `IDX_CLOCK_RATE_CONTROL) & wstrb_reg[0]) begin
				hs_en_reg <= wdata_reg[0];
			end
		end
	end

	// ==========================================================
	// AXI4-Lite read path
	// ==========================================================
	// Read word decode; bits above each register read zero.
	always_comb begin
		rd_hit  = 1'b1;
		rd_word = 32'h0000_0000;
		case (S_AXI_ARADDR[7:2])
			`IDX_TIMER_A_INPUT_SOURCE_SELECT: rd_word[15:0] = tsel_reg;
			`IDX_PERIPH_CLOCK_ENABLE:         rd_word[7:0] = clken_reg;
			`IDX_STOP_DISABLE:                rd_word[7:0] = stopdis_reg;
			`IDX_CLOCK_RATE_CONTROL:          rd_word[0] = hs_en_reg;
			`IDX_POWER_STATUS: begin
				rd_word[1:0] = mode_reg;
				rd_word[2]   = standby_cfg;
				rd_word[4:3] = osc_speed;
				rd_word[6:5] = MASTER_OSCILLATOR_SOURCE;
				rd_word[7]   = PLL_SELECT;
				rd_word[8]   = |fast_en;
			end
			default: rd_hit = 1'b0;
		endcase
	end

	assign S_AXI_ARREADY = ~rvalid_reg;

	// One read at a time, answered the cycle after the address is taken.
	always_ff @(posedge REF_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= 32'h0000_0000;
			rresp_reg  <= clkpm_pkg::RESP_OKAY;
		end else if (S_AXI_ARVALID & ~rvalid_reg) begin
			rvalid_reg <= 1'b1;
			rdata_reg  <= rd_word;
			rresp_reg  <= rd_hit ? clkpm_pkg::RESP_OKAY : clkpm_pkg::RESP_SLVERR;
		end else if (rvalid_reg & S_AXI_RREADY) begin
			rvalid_reg <= 1'b0;
		end
	end

	assign S_AXI_RVALID = rvalid_reg;
	assign S_AXI_RDATA  = rdata_reg;
	assign S_AXI_RRESP  = rresp_reg;

	// ==========================================================
	// Assertions
	// ==========================================================
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (SYS_RST);

	sequence stop_enter;
		mode_reg == clkpm_pkg::MODE_RUN && STOP_REQ && !pdown_cond;
	endsequence

	sequence stopped;
		mode_reg == clkpm_pkg::MODE_STOP && !core_en;
	endsequence

	a_ch3_route: assert property (##1 TIMER_CH3_IN == ($past(tsel_reg[12]) ?
		$past(PWM_RELOAD_SYNC) : $past(sync2_reg[2]))) else $error("ch3 source wrong");
	a_ch2_route: assert property (##1 TIMER_CH2_IN == ($past(tsel_reg[8]) ?
		$past(sync2_reg[4]) : $past(sync2_reg[1]))) else $error("ch2 source wrong");
	a_ch1_route: assert property (##1 TIMER_CH1_IN == ($past(tsel_reg[4]) ?
		$past(sync2_reg[3]) : $past(sync2_reg[0]))) else $error("ch1 source wrong");
	a_reserved_zero: assert property ((tsel_reg & ~`TSEL_WRITE_MASK) == 16'h0000)
		else $error("reserved select bit set");
	// The divider is held at the release edge, so the check starts one edge later.
	a_sysclk_toggle: assert property (!$past(SYS_RST) |->
		sys_div_reg != $past(sys_div_reg)) else $error("system clock not halving");
	a_fast_no_pll: assert property (!PLL_SELECT || standby_cfg |-> fast_en == 4'h0)
		else $error("3X clock without PLL");
	a_hs_needs_pll: assert property (!pll_ok |=> !hs_en_reg)
		else $error("high-speed option kept without PLL");
	a_run_all_on: assert property (mode_reg == clkpm_pkg::MODE_RUN |->
		core_en && periph_en == clken_reg) else $error("run mode clock off");
	a_wait_wakes: assert property (mode_reg == clkpm_pkg::MODE_WAIT && any_irq |=>
		mode_reg == clkpm_pkg::MODE_RUN) else $error("wait not left on interrupt");
	a_stop_entry: assert property (stop_enter |=> stopped [*1] ##0
		periph_en == (clken_reg & stopdis_reg)) else $error("stop entry wrong");
	a_pdown_sticks: assert property (mode_reg == clkpm_pkg::MODE_PDOWN |=>
		mode_reg == clkpm_pkg::MODE_PDOWN && periph_en == 8'h00 && !core_en)
		else $error("power-down left without reset");
	a_wdog_period: assert property ($changed(wdog_clk_reg) &&
		mode_reg != clkpm_pkg::MODE_PDOWN |-> $past(wdog_cnt_reg) == `WDOG_HALF_CNT)
		else $error("watchdog divider wrong");

endmodule

// ### sim/clock_source_model.sv
`include "clkpm_params.svh"
// ==========================================
// Clock generation side: oscillator, 3X clock and standby controls.
module clock_source_model (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       standby_req,
	input  wire logic       pdown_req,
	output logic            oscillator_clock,
	output logic            fast_clk,
	output logic [1:0]      src,
	output logic            pll_sel,
	output logic            pll_pd,
	output logic            relax_osc_standby,
	output logic            relax_osc_powerdown,
	output logic            large_regulator_standby
);
	timeunit 1ns;
	timeprecision 1ps;
	int step;

	// Walks one control per cycle; step 1 deselects the PLL.
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			step <= 0;
		else if (standby_req && step < 5)
			step <= step + 1;
		else if (!standby_req && step > 0)
			step <= step - 1;
	end

	// The regulator goes to standby only after the PLL is deselected.
	assign pll_sel = step == 0;
	assign src     = step >= 2 ? `OSC_SRC_RELAX : 2'h0;
	assign pll_pd  = step >= 3;
	assign relax_osc_standby    = step >= 4;
	assign large_regulator_standby = step >= 5;
	assign relax_osc_powerdown    = pdown_req && large_regulator_standby;

	// The oscillator slows in standby and stops when powered down.
	initial begin
		oscillator_clock = 1'b0;
		forever begin
			#(relax_osc_standby ? 40.0 : 5.0);
			oscillator_clock = !oscillator_clock && !relax_osc_powerdown;
		end
	end

	// The 3X clock runs only while the PLL is selected.
	initial begin
		fast_clk = 1'b0;
		forever begin
			#1.333;
			fast_clk = !fast_clk && pll_sel;
		end
	end
endmodule

// ### sim/system_clock_power_mode_control_tb.sv
`include "clkpm_params.svh"
module system_clock_power_mode_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, rst, sbr, pdr, osc, f3x, psel, ppd, rsb, rpd, lrs, ca, cb, pws, core, wdog;
	logic        awv, awr, wv, wrd, bv, brd, arv, arr, rv, rrd, wq, sq, dbg, lvi;
	logic [1:0]  msrc, bresp, rresp, mode;
	logic [7:0]  awaddr, araddr, irq, pclk;
	logic [31:0] wdata, rdata;
	logic [3:0]  fclk;
	logic [2:0]  pin, tin;
	int          failures, cmp_count, oscn, t;

	// Block under test, with the partner model on the clock generation side.
	system_clock_power_mode_control u_system_clock_power_mode_control (
		.REF_CLK(clk), .SYS_RST(rst), .FAST_CLK_3X(f3x), .OSCILLATOR_CLOCK(osc),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(brd),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rrd),
		.WAIT_REQ(wq), .STOP_REQ(sq), .DEBUG_ENTRY(dbg), .LVI_IRQ(lvi), .PERIPH_IRQ(irq),
		.MASTER_OSCILLATOR_SOURCE(msrc), .PLL_SELECT(psel), .PLL_POWERDOWN(ppd),
		.RELAX_OSC_STANDBY(rsb), .RELAX_OSC_POWERDOWN(rpd), .LARGE_REGULATOR_STANDBY(lrs),
		.TIMER_CH1_PIN(pin[0]), .TIMER_CH2_PIN(pin[1]), .TIMER_CH3_PIN(pin[2]),
		.COMPARATOR_FIRST_OUT(ca), .COMPARATOR_SECOND_OUT(cb), .PWM_RELOAD_SYNC(pws),
		.TIMER_CH1_IN(tin[0]), .TIMER_CH2_IN(tin[1]), .TIMER_CH3_IN(tin[2]),
		.CORE_CLK(core), .PERIPH_CLK(pclk), .FAST_PERIPH_CLK(fclk), .WATCHDOG_CLK(wdog),
		.POWER_MODE(mode)
	);
	clock_source_model u_clock_source_model (
		.clk(clk), .rst(rst), .standby_req(sbr), .pdown_req(pdr), .oscillator_clock(osc),
		.fast_clk(f3x), .src(msrc), .pll_sel(psel), .pll_pd(ppd), .relax_osc_standby(rsb),
		.relax_osc_powerdown(rpd), .large_regulator_standby(lrs)
	);

	// Clock, oscillator edge count, and the hang guard.
	initial begin
		clk = 1'b0;
		forever #2 clk = !clk;
	end
	always @(posedge osc) oscn <= oscn + 1;
	initial begin
		#60us;
		failures++;
		tally_and_finish();
	end

	// ==========================================
	// Shared tasks.
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One register access; a write holds each channel until it is taken.
	task automatic xfer(input logic w, input logic [5:0] ix, input logic [31:0] d,
			input logic [1:0] er = 2'h0);
		logic [34:0] r;
		logic        a, b;
		int          n;
		r = '0;
		n = 0;
		if (w) begin
			{awaddr, wdata} <= {ix, 2'b00, d};
			{awv, wv, brd} <= 3'b111;
		end else begin
			araddr <= {ix, 2'b00};
			{arv, rrd} <= 2'b11;
		end
		while (!r[34] && n < 200) begin
			@(negedge clk);
			a = awv && awr || arv && arr;
			b = wv && wrd;
			r = w ? {bv, bresp, 32'h0} : {rv, rresp, rdata};
			@(posedge clk);
			if (a) {awv, arv} <= 2'b00;
			if (b) wv <= 1'b0;
			n++;
		end
		{brd, rrd} <= 2'b00;
		@(posedge clk);
		chk("resp", r[34:32], {1'b1, er});
		if (!w) chk("rdata", r[31:0], d);
	endtask

	// Records which clocks pulse high within ten cycles.
	task automatic see(input logic [12:0] exp, input logic [12:0] m = 13'h1FFF);
		logic [12:0] s;
		s = '0;
		repeat (6) @(posedge clk);
		#0.25;
		repeat (79) begin
			#0.5;
			s = s | {fclk, core, pclk};
		end
		@(posedge clk);
		chk("clocks", s & m, exp);
	endtask

	task automatic enter(input logic s);
		{sq, wq} <= {s, !s};
		@(posedge clk);
		{sq, wq} <= 2'b00;
		@(posedge clk);
	endtask

	task automatic wake(input logic [9:0] v);
		{dbg, lvi, irq} <= v;
		@(posedge clk);
		{dbg, lvi, irq} <= '0;
		@(posedge clk);
	endtask

	task automatic mchk(input logic [1:0] exp);
		@(negedge clk);
		chk("mode", mode, exp);
		@(posedge clk);
	endtask

	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ==========================================
	// Test sequence.
	initial begin
		{awv, wv, brd, arv, rrd, wq, sq, dbg, lvi, sbr, pdr, ca, cb, pws} = '0;
		{awaddr, araddr, irq, wdata, pin} = '0;
		rst = 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		xfer(0, `IDX_TIMER_A_INPUT_SOURCE_SELECT, 32'h0);
		xfer(0, `IDX_PERIPH_CLOCK_ENABLE, 32'hFF);
		xfer(0, `IDX_STOP_DISABLE, 32'h0);
		xfer(1, 6'h3F, 32'h1, 2'h2);
		xfer(1, `IDX_POWER_STATUS, 32'h1, 2'h2);
		// Each timer input follows its pin or its internal source.
		for (int s = 0; s < 2; s++) begin
			xfer(1, `IDX_TIMER_A_INPUT_SOURCE_SELECT, s ? 32'h1110 : 32'h0);
			xfer(0, `IDX_TIMER_A_INPUT_SOURCE_SELECT, s ? 32'h1110 : 32'h0);
			for (int v = 0; v < 8; v++) begin
				pin <= v[2:0];
				{pws, cb, ca} <= ~v[2:0];
				repeat (4) @(posedge clk);
				@(negedge clk);
				chk("tin", tin, s ? {~v[2:0]} : v[2:0]);
				@(posedge clk);
			end
		end
		// Gating by enables, fast option and modes.
		see(13'h01FF);
		xfer(1, `IDX_CLOCK_RATE_CONTROL, 32'h1);
		xfer(0, `IDX_CLOCK_RATE_CONTROL, 32'h1);
		see(13'h1FFF);
		xfer(1, `IDX_PERIPH_CLOCK_ENABLE, 32'hFE);
		see(13'h1DFE);
		enter(1'b0);
		mchk(clkpm_pkg::MODE_WAIT);
		see(13'h1CFE);
		wake(10'h020);
		mchk(clkpm_pkg::MODE_RUN);
		enter(1'b0);
		wake(10'h200);
		mchk(clkpm_pkg::MODE_RUN);
		xfer(1, `IDX_STOP_DISABLE, 32'h03);
		enter(1'b1);
		mchk(clkpm_pkg::MODE_STOP);
		see(13'h0002, 13'h01FF);
		wake(10'h005);
		mchk(clkpm_pkg::MODE_STOP);
		wake(10'h100);
		mchk(clkpm_pkg::MODE_RUN);
		enter(1'b1);
		wake(10'h002);
		mchk(clkpm_pkg::MODE_RUN);
		@(posedge wdog);
		t = oscn;
		@(posedge wdog);
		chk("wdog", oscn - t, `WDOG_DIV);
		// Standby, then power-down until reset.
		sbr <= 1'b1;
		repeat (10) @(posedge clk);
		xfer(0, `IDX_POWER_STATUS, 32'h4C);
		xfer(0, `IDX_CLOCK_RATE_CONTROL, 32'h0);
		see(13'h01FE);
		// Wait is still reachable while the standby configuration stands.
		enter(1'b0);
		mchk(clkpm_pkg::MODE_WAIT);
		wake(10'h100);
		mchk(clkpm_pkg::MODE_RUN);
		pdr <= 1'b1;
		repeat (3) @(posedge clk);
		mchk(clkpm_pkg::MODE_PDOWN);
		see(13'h0);
		wake(10'h3FF);
		mchk(clkpm_pkg::MODE_PDOWN);
		{rst, sbr, pdr} <= 3'b100;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		mchk(clkpm_pkg::MODE_RUN);
		tally_and_finish();
	end
endmodule
